/* verilog/csrl_supervisor.sv */
// Processor supervisor: supply fail reset, push-button, watchdog and SRAM gating
`timescale 1ns/1ps
module csrl_supervisor
  import csrl_pkg::*;
#(
  parameter int unsigned POR_TICKS_P  = POR_TICKS,
  parameter int unsigned WDOG_TICKS_P = WDOG_TICKS
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic xtal_clk_i,
  input  wire logic supply_ok_i,
  input  wire logic wdog_kick_n_i,
  input  wire logic rst_pin_n_i,
  output logic      rst_n_o,
  output logic      rst_n_oe_o,
  input  wire logic sram_sel_in_n_i,
  output logic      sram_sel_out_n_o,
  input  wire logic pwrwarn_below_i,
  output logic      pwrwarn_out_n_o,
  input  wire logic alarm_flag_i,
  input  wire logic alarm_irq_en_i,
  output logic      irq_o,
  output logic      xtal_lost_o
);

  csrl_pins_s               pin_raw;
  csrl_pins_s               pin_m;
  csrl_pins_s               sy;
  logic                     xtal_d;
  logic                     xtick;
  logic [XD_W-1:0]          xdead_cnt;
  logic                     xdead;
  logic                     kick_d;
  logic                     kick_fell;
  logic                     pb_low;
  logic [DEB_W-1:0]         deb_cnt;
  logic                     pb_hit;
  logic [TMR_W-1:0]         tmr;
  logic [TMR_W-1:0]         wdog_cnt;
  logic                     wdog_expire;
  logic                     tmr_done;
  csrl_state_e              state;
  csrl_state_e              next_state;
  logic                     hold_off;

  assign pin_raw = '{supply_ok: supply_ok_i, kick_n: wdog_kick_n_i, rst_pin_n: rst_pin_n_i,
                     sram_sel_n: sram_sel_in_n_i, warn_below: pwrwarn_below_i, xtal: xtal_clk_i};

  // Every pin except the alarm flag and enable crosses two flops; only the second stage is read
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_m <= PINS_RST;
      sy    <= PINS_RST;
    end else begin
      pin_m <= pin_raw;
      sy    <= pin_m;
    end
  end

  // Crystal rising edge is the timebase tick
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      xtal_d <= 1'b0;
      kick_d <= 1'b1;
    end else begin
      xtal_d <= sy.xtal;
      kick_d <= sy.kick_n;
    end
  end
  assign xtick     = sy.xtal & ~xtal_d;
  assign kick_fell = kick_d & ~sy.kick_n;

  // A stopped crystal freezes all timing, so the block holds the processor in reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      xdead_cnt <= '0;
    end else if (xtick) begin
      xdead_cnt <= '0;
    end else if (!xdead) begin
      xdead_cnt <= xdead_cnt + XD_W'(1);
    end
  end
  assign xdead = (xdead_cnt == XD_W'(XTAL_DEAD_CYC));

  // Push-button: the pin must read low while not driven here for the debounce time.
  // Release of our own drive leaves the pin low a few cycles; far shorter than debounce.
  assign pb_low = ~sy.rst_pin_n & ~rst_n_oe_o;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      deb_cnt <= '0;
    end else if (!pb_low || state != S_RUN) begin
      deb_cnt <= '0;
    end else if (xtick && !pb_hit) begin
      deb_cnt <= deb_cnt + DEB_W'(1);
    end
  end
  assign pb_hit = (deb_cnt == DEB_W'(DEB_TICKS));

  // Watchdog runs only while the processor is out of reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wdog_cnt <= '0;
    end else if (state != S_RUN || kick_fell) begin
      wdog_cnt <= '0;
    end else if (xtick) begin
      wdog_cnt <= wdog_cnt + TMR_W'(1);
    end
  end
  assign wdog_expire = xtick && !kick_fell && (wdog_cnt == TMR_W'(WDOG_TICKS_P - 1));

  // Reset-width timer shared by lockout and stretched resets
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tmr <= '0;
    end else if (next_state != state || state == S_RUN || state == S_FAIL) begin
      tmr <= '0;
    end else if (xtick) begin
      tmr <= tmr + TMR_W'(1);
    end
  end
  assign tmr_done = xtick && (tmr == TMR_W'(POR_TICKS_P - 1));

  always_comb begin
    next_state = state;
    if (!sy.supply_ok) begin
      next_state = S_FAIL;
    end else begin
      unique case (state)
        S_FAIL:    next_state = S_LOCKOUT;
        S_LOCKOUT: if (tmr_done) begin
          next_state = S_RUN;
        end
        S_RUN:     if (pb_hit || wdog_expire) begin
          next_state = S_STRETCH;
        end
        S_STRETCH: if (tmr_done && !pb_low) begin
          next_state = S_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= S_FAIL;
    end else begin
      state <= next_state;
    end
  end

  // The button, watchdog strobe and SRAM select inputs are ignored until lockout ends
  assign hold_off = (state == S_FAIL) || (state == S_LOCKOUT);

  // Open-drain: the output level is always low, only the enable moves
  assign rst_n_o     = 1'b0;
  assign rst_n_oe_o  = (state != S_RUN) || xdead;
  assign xtal_lost_o = xdead;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sram_sel_out_n_o <= 1'b1;
      pwrwarn_out_n_o  <= 1'b1;
      irq_o            <= 1'b0;
    end else begin
      sram_sel_out_n_o <= sy.sram_sel_n | hold_off | xdead | ~sy.supply_ok;
      pwrwarn_out_n_o  <= ~sy.warn_below;
      irq_o            <= alarm_flag_i & alarm_irq_en_i;
    end
  end

  default clocking dc @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_fail_forces_reset: assert property (!sy.supply_ok |=> state == S_FAIL && rst_n_oe_o)
    else $error("supply failure did not force reset");
  a_lockout_holds: assert property (state == S_LOCKOUT && !tmr_done && sy.supply_ok |=> state == S_LOCKOUT)
    else $error("lockout ended early");
  a_lockout_ends: assert property (state == S_LOCKOUT && tmr_done && sy.supply_ok |=> state == S_RUN)
    else $error("lockout did not end on time");
  a_button_stretch: assert property (state == S_STRETCH && !tmr_done && sy.supply_ok |=> state == S_STRETCH)
    else $error("button reset shorter than required");
  a_button_taken: assert property (state == S_RUN && pb_hit && sy.supply_ok |=> rst_n_oe_o)
    else $error("debounced button did not reset");
  a_wdog_timeout: assert property (state == S_RUN && wdog_expire && sy.supply_ok |=> state == S_STRETCH)
    else $error("watchdog expiry missed");
  a_open_drain: assert property (rst_n_oe_o |-> rst_n_o == 1'b0)
    else $error("reset pin driven high");
  a_irq_follow: assert property (alarm_flag_i && alarm_irq_en_i |=> irq_o)
    else $error("interrupt not raised");
  a_irq_masked: assert property (!alarm_irq_en_i |=> !irq_o)
    else $error("interrupt raised while disabled");
  a_sram_blocked: assert property (hold_off |=> sram_sel_out_n_o)
    else $error("SRAM selected during lockout");
  a_sram_transient: assert property (!sy.supply_ok |=> sram_sel_out_n_o ##1 sram_sel_out_n_o)
    else $error("SRAM select leaked in transient");
  a_warn_follow: assert property (sy.warn_below |=> !pwrwarn_out_n_o)
    else $error("power warning not shown");
  a_kick_restart: assert property (state == S_RUN && kick_fell |=> wdog_cnt == '0)
    else $error("strobe did not restart watchdog");
  a_xtal_lost: assert property (xdead |-> rst_n_oe_o ##1 sram_sel_out_n_o)
    else $error("crystal loss not handled");
  a_lost_release: assert property (xtick |=> !xtal_lost_o)
    else $error("crystal loss kept after an edge");
  a_xdead_bounded: assert property (xdead_cnt <= XD_W'(XTAL_DEAD_CYC))
    else $error("crystal loss counter overran");
  a_warn_clear: assert property (!sy.warn_below |=> pwrwarn_out_n_o)
    else $error("power warning shown without cause");
  a_irq_clear: assert property (!alarm_flag_i |=> !irq_o)
    else $error("interrupt raised without flag");
  a_sram_pass: assert property (sy.supply_ok && !hold_off && !xdead
    |=> sram_sel_out_n_o == $past(sy.sram_sel_n))
    else $error("SRAM select not passed through");
  a_wdog_parked: assert property (hold_off |=> wdog_cnt == '0)
    else $error("watchdog ran during lockout");
  a_deb_parked: assert property (hold_off |=> deb_cnt == '0)
    else $error("button counted during lockout");
  a_stretch_ends: assert property (state == S_STRETCH && tmr_done && sy.supply_ok |=> state == S_RUN)
    else $error("stretched reset did not end");
  a_tmr_bounded: assert property ((state == S_LOCKOUT || state == S_STRETCH) |-> tmr < TMR_W'(POR_TICKS_P))
    else $error("reset width timer overran");

endmodule : csrl_supervisor

/* verilog/csrl_pkg.sv */
// Constants, types and behaviour notes for the supervisor reset logic
package csrl_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned XTAL_HZ        = 32768;
  localparam int unsigned POR_TIME_MS    = 250;
  localparam int unsigned WDOG_TIME_MS   = 1500;
  localparam int unsigned DEB_TIME_US    = 500;
  localparam int unsigned XTAL_DEAD_NS   = 61035;
  // Least times round up, the crystal-loss limit rounds down
  localparam int unsigned POR_TICKS      = (POR_TIME_MS * XTAL_HZ + 999) / 1000;
  localparam int unsigned WDOG_TICKS     = (WDOG_TIME_MS * XTAL_HZ + 999) / 1000;
  localparam int unsigned DEB_TICKS      = (DEB_TIME_US * XTAL_HZ + 999999) / 1000000;
  localparam int unsigned XTAL_DEAD_CYC  = XTAL_DEAD_NS / CLK_PERIOD_NS;

  localparam int unsigned TMR_W          = 17;
  localparam int unsigned DEB_W          = 5;
  localparam int unsigned XD_W           = 12;

  typedef enum logic [1:0] {
    S_FAIL,
    S_LOCKOUT,
    S_RUN,
    S_STRETCH
  } csrl_state_e;

  // Pin levels passed through the two-stage synchroniser together
  typedef struct packed {
    logic supply_ok;
    logic kick_n;
    logic rst_pin_n;
    logic sram_sel_n;
    logic warn_below;
    logic xtal;
  } csrl_pins_s;

  localparam csrl_pins_s PINS_RST = '{supply_ok: 1'b0, kick_n: 1'b1, rst_pin_n: 1'b1,
                                      sram_sel_n: 1'b1, warn_below: 1'b0, xtal: 1'b0};

endpackage : csrl_pkg

/* tb/csrl_far_model.sv */
// Far side model: crystal, push-button and the pulled-up reset wire
`timescale 1ns/1ps
module csrl_far_model (
  input  wire logic xtal_on_i,
  input  wire logic button_n_i,
  input  wire logic rst_n_i,
  input  wire logic rst_n_oe_i,
  output logic      xtal_o,
  output logic      rst_wire_n_o
);
  // Crystal stands still when stopped, so loss detection sees no edges
  initial begin
    xtal_o = 1'b0;
    forever #250 xtal_o = xtal_on_i ? ~xtal_o : 1'b0;
  end
  // Weak pull-up wins only while nobody pulls low
  assign rst_wire_n_o = (rst_n_oe_i ? rst_n_i : 1'b1) & button_n_i;
endmodule : csrl_far_model

/* tb/tb.sv */
// Self-checking bench for the supervisor reset logic
`timescale 1ns/1ps
module tb;
  import csrl_pkg::*;
  localparam int POR = 20;
  localparam int WD  = 40;
  logic       mclk_i, rst_i, xtal_on, button_n, xtal, wire_n, supply_ok, kick_n;
  logic       sel_n, below, flag, en, rst_n, oe, sel_out_n, warn_n, irq, lost;
  logic [7:0] lf;
  int         num_errors, n_compared;

  csrl_far_model u_far (.xtal_on_i(xtal_on), .button_n_i(button_n), .rst_n_i(rst_n),
    .rst_n_oe_i(oe), .xtal_o(xtal), .rst_wire_n_o(wire_n));
  csrl_supervisor #(.POR_TICKS_P(POR), .WDOG_TICKS_P(WD)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .xtal_clk_i(xtal), .supply_ok_i(supply_ok), .wdog_kick_n_i(kick_n), .rst_pin_n_i(wire_n),
    .rst_n_o(rst_n), .rst_n_oe_o(oe), .sram_sel_in_n_i(sel_n), .sram_sel_out_n_o(sel_out_n),
    .pwrwarn_below_i(below), .pwrwarn_out_n_o(warn_n), .alarm_flag_i(flag),
    .alarm_irq_en_i(en), .irq_o(irq), .xtal_lost_o(lost));

  task automatic chk(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One crystal tick is 20 system clocks
  task automatic tk(input int n);
    repeat (n * 20) @(negedge mclk_i);
  endtask : tk
  task automatic kick;
    kick_n = 1'b1;
    @(negedge mclk_i);
    kick_n = 1'b0;
    tk(1);
    kick_n = 1'b1;
  endtask : kick
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  function automatic logic want_irq(input logic f, input logic e);
    return f & e;
  endfunction : want_irq
  task automatic end_of_test;
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // Whole run needs well under 1 ms
  initial begin
    #1ms;
    num_errors++;
    end_of_test();
  end

  initial begin
    rst_i = 1'b1; xtal_on = 1'b1; button_n = 1'b1; supply_ok = 1'b1; kick_n = 1'b1;
    sel_n = 1'b0; below = 1'b0; flag = 1'b0; en = 1'b0; lf = 8'h53;
    num_errors = 0; n_compared = 0;
    repeat (6) @(negedge mclk_i);
    rst_i = 1'b0;
    tk(1);
    chk(oe, 1'b1);
    chk(rst_n, 1'b0);
    tk(POR - 3);
    chk(oe, 1'b1);
    chk(sel_out_n, 1'b1);
    tk(6);
    chk(oe, 1'b0);
    chk(lost, 1'b0);
    for (int i = 0; i < 40; i++) begin
      lf = lfsr(lf);
      {sel_n, below, flag, en} = lf[3:0];
      kick_n = lf[4];
      repeat (4) @(negedge mclk_i);
      chk(sel_out_n, sel_n);
      chk(warn_n, ~below);
      chk(irq, want_irq(flag, en));
    end
    for (int i = 0; i < 3; i++) begin
      kick();
      tk(WD - 10);
    end
    chk(oe, 1'b0);
    kick();
    tk(WD - 5);
    chk(oe, 1'b0);
    tk(8);
    chk(oe, 1'b1);
    tk(POR + 3);
    chk(oe, 1'b0);
    kick();
    button_n = 1'b0;
    tk(10);
    button_n = 1'b1;
    tk(2);
    chk(oe, 1'b0);
    button_n = 1'b0;
    tk(19);
    button_n = 1'b1;
    chk(oe, 1'b1);
    tk(POR - 4);
    chk(oe, 1'b1);
    tk(8);
    chk(oe, 1'b0);
    kick();
    sel_n = 1'b0;
    supply_ok = 1'b0;
    repeat (4) @(negedge mclk_i);
    chk(oe, 1'b1);
    chk(sel_out_n, 1'b1);
    supply_ok = 1'b1;
    tk(POR - 3);
    chk(oe, 1'b1);
    chk(sel_out_n, 1'b1);
    tk(6);
    chk(oe, 1'b0);
    xtal_on = 1'b0;
    repeat (2500) @(negedge mclk_i);
    chk(lost, 1'b1);
    chk(oe, 1'b1);
    chk(sel_out_n, 1'b1);
    end_of_test();
  end
endmodule : tb
